// ==== core/cmc_defines.svh ====
`ifndef CMC_DEFINES_SVH
`define CMC_DEFINES_SVH

// Transmit buffers
`define CMC_NBUF          4
`define CMC_BUFW          2

// Register byte offsets (haddr[7:0])
`define CMC_ADDR_W        8
`define CMC_OFF_CTRL      8'h00
`define CMC_OFF_TEST      8'h04
`define CMC_OFF_PEND      8'h08
`define CMC_OFF_CANCEL    8'h0c
`define CMC_OFF_SENT      8'h10
`define CMC_OFF_ABORT     8'h14
`define CMC_OFF_STAT      8'h18

// Control register fields
`define CMC_CTRL_HOLD     0
`define CMC_CTRL_DIAG     1
`define CMC_CTRL_LISTEN   2
`define CMC_CTRL_NORETRY  3
`define CMC_CTRL_CSR      4
`define CMC_CTRL_CSA      5
`define CMC_CTRL_RESTR    6
`define CMC_CTRL_EVTEN    7
`define CMC_HOLD_RST      1'b1

// Test register fields
`define CMC_TEST_DRV_LO   0
`define CMC_TEST_DRV_HI   1
`define CMC_TEST_LBK      2
`define CMC_TEST_RXS      3

// Status register fields
`define CMC_STAT_MON      0
`define CMC_STAT_IDLE     1
`define CMC_STAT_TIER_LO  2
`define CMC_STAT_TIER_HI  3
`define CMC_STAT_CS_LO    4
`define CMC_STAT_CS_HI    6

// Codes
`define CMC_TIER_SEVERE   2'h3
`define CMC_EVT_TX        2'h1
`define CMC_EVT_DESPITE   2'h2
`define CMC_RECESSIVE     1'b1
`define CMC_DOMINANT      1'b0
`define CMC_HSIZE_WORD    3'h2
`define CMC_HTRANS_ACT    1

`endif

// ==== core/cmc_pkg.sv ====
package cmc_pkg;

	typedef enum logic [2:0] {
		CMC_CS_RUN   = 3'h0,
		CMC_CS_DRAIN = 3'h1,
		CMC_CS_IDLEW = 3'h2,
		CMC_CS_HOLD  = 3'h3,
		CMC_CS_ACK   = 3'h4
	} cmc_cs_state_t;

	typedef enum logic [1:0] {
		CMC_DRV_SERIAL    = 2'h0,
		CMC_DRV_SAMPLE    = 2'h1,
		CMC_DRV_DOMINANT  = 2'h2,
		CMC_DRV_RECESSIVE = 2'h3
	} cmc_drive_t;

endpackage

// ==== core/cmc_sync.sv ====
module cmc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else if (clk_en) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

// ==== core/cmc_top.sv ====
`include "cmc_defines.svh"

// Contract
// - Monitoring when listen_only_bit set or fault tier reaches severe 11.
// - Monitoring still receives frames but never starts own transmission.
// - Monitoring keeps transmit pin recessive; dominant bits loop back inside.
// - Monitoring holds the pending register in its reset state.
// - Automatic retry active after reset, off when retry_disable_bit set.
// - Retry off: started frames cancel; pending clears on any outcome.
// - Success sets sent; success plus cancel sets both; loss sets abort when retry off or cancel set.
// - Retry off with event storage: success writes event type 10.
// - Stop requested by input or bit; bit reads one while input high.
// - On stop request drain pending, await bus idle, then set hold.
// - After hold set, assert stop acknowledge output and ack bit.
// - While acknowledged registers stay accessible; hold writes ignored.
// - Withdrawn request drops ack; software later clears hold bit.
// - Test register writable only while diag_access_enable is one.
// - Drive field picks serial, sample strobe, dominant or recessive.
// - Receive pin level readable through synchronised receive sample field.
// - Drive and receive sample changes take several clocks through sync.
// - Loop back treats own transmitted frames as received frames.
// - Loop back suppresses acknowledge error on recessive ack slot.
// - External loop back feeds transmit to receiver, ignores receive pin.
// - Loop back plus listen only: internal, pin disconnected, tx recessive.
module cmc_top (
	// Clock, reset, enable
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	input  wire logic                   clk_en,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic      [31:0]            hrdata,
	// CAN pins
	output logic                        can_tx,
	input  wire logic                   can_rx,
	// Power down handshake
	input  wire logic                   clock_stop_req_in,
	output logic                        clock_stop_ack_out,
	// Protocol core status
	input  wire logic                   core_tx_bit,
	input  wire logic                   core_sample_point,
	input  wire logic                   core_bus_idle,
	input  wire logic [1:0]             fault_tier,
	// Protocol core transmit events
	input  wire logic                   tx_start,
	input  wire logic [`CMC_BUFW-1:0]   tx_buf_idx,
	input  wire logic                   tx_success,
	input  wire logic                   tx_arb_lost,
	input  wire logic                   tx_error,
	// Protocol core controls
	output logic                        core_rx_bit,
	output logic      [`CMC_NBUF-1:0]   tx_request,
	output logic                        tx_auto_retry,
	output logic                        ack_error_mask,
	output logic                        loopback_store,
	output logic                        restricted_op,
	output logic                        config_hold,
	// Transmit event entry
	output logic                        evt_wr,
	output logic      [1:0]             evt_type,
	output logic      [`CMC_BUFW-1:0]   evt_buf
);

	function automatic logic reg_hit(input logic [`CMC_ADDR_W-1:0] a,
	                                 input logic [`CMC_ADDR_W-1:0] off);
		reg_hit = (a == off);
	endfunction

	function automatic logic [`CMC_NBUF-1:0] buf_sel(
		input logic [`CMC_BUFW-1:0] idx);
		buf_sel = '0;
		buf_sel[idx] = 1'b1;
	endfunction

	logic                    dp_wr_q;
	logic                    rd_wait_q;
	logic [`CMC_ADDR_W-1:0]  dp_addr_q;
	logic                    addr_phase;
	logic [31:0]             rd_value;
	logic                    wr_ctrl;
	logic                    wr_test;
	logic                    wr_pend;
	logic                    wr_cancel;

	logic                    diag_en_q;
	logic                    listen_q;
	logic                    noretry_q;
	logic                    csr_q;
	logic                    restr_q;
	logic                    evt_en_q;
	logic                    hold_q;
	logic [1:0]              drive_q;
	logic                    lbk_q;
	logic [1:0]              drive_sync;
	logic                    rx_sample;

	logic [`CMC_NBUF-1:0]    pend_q;
	logic [`CMC_NBUF-1:0]    cancel_q;
	logic [`CMC_NBUF-1:0]    started_q;
	logic [`CMC_NBUF-1:0]    sent_q;
	logic [`CMC_NBUF-1:0]    abort_q;
	logic [`CMC_NBUF-1:0]    cur_sel;
	logic                    frame_end;
	logic                    frame_fail;

	logic                    monitor;
	logic                    int_loop;
	logic                    stop_req;
	cmc_pkg::cmc_cs_state_t  cs_q;
	cmc_pkg::cmc_cs_state_t  cs_d;

	// AHB-Lite address and data phases
	assign addr_phase = hsel && hready && htrans[`CMC_HTRANS_ACT];
	assign hreadyout  = !rd_wait_q;
	assign hresp      = 1'b0;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dp_wr_q   <= 1'b0;
			rd_wait_q <= 1'b0;
			dp_addr_q <= '0;
		end else if (clk_en) begin
			if (hready) begin
				dp_wr_q   <= addr_phase && hwrite &&
				             (hsize == `CMC_HSIZE_WORD);
				rd_wait_q <= addr_phase && !hwrite;
				if (addr_phase) begin
					dp_addr_q <= haddr[`CMC_ADDR_W-1:0];
				end
			end else begin
				rd_wait_q <= 1'b0;
			end
		end
	end

	// Read data is captured in the single wait cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= '0;
		end else if (clk_en && rd_wait_q) begin
			hrdata <= rd_value;
		end
	end

	assign wr_ctrl   = dp_wr_q && reg_hit(dp_addr_q, `CMC_OFF_CTRL);
	assign wr_test   = dp_wr_q && reg_hit(dp_addr_q, `CMC_OFF_TEST);
	assign wr_pend   = dp_wr_q && reg_hit(dp_addr_q, `CMC_OFF_PEND);
	assign wr_cancel = dp_wr_q && reg_hit(dp_addr_q, `CMC_OFF_CANCEL);

	always_comb begin
		rd_value = '0;
		if (reg_hit(dp_addr_q, `CMC_OFF_CTRL)) begin
			rd_value[`CMC_CTRL_HOLD]    = hold_q;
			rd_value[`CMC_CTRL_DIAG]    = diag_en_q;
			rd_value[`CMC_CTRL_LISTEN]  = listen_q;
			rd_value[`CMC_CTRL_NORETRY] = noretry_q;
			rd_value[`CMC_CTRL_CSR]     = stop_req;
			rd_value[`CMC_CTRL_CSA]     = clock_stop_ack_out;
			rd_value[`CMC_CTRL_RESTR]   = restr_q;
			rd_value[`CMC_CTRL_EVTEN]   = evt_en_q;
		end else if (reg_hit(dp_addr_q, `CMC_OFF_TEST)) begin
			rd_value[`CMC_TEST_DRV_HI:`CMC_TEST_DRV_LO] = drive_q;
			rd_value[`CMC_TEST_LBK] = lbk_q;
			rd_value[`CMC_TEST_RXS] = rx_sample;
		end else if (reg_hit(dp_addr_q, `CMC_OFF_PEND)) begin
			rd_value[`CMC_NBUF-1:0] = pend_q;
		end else if (reg_hit(dp_addr_q, `CMC_OFF_CANCEL)) begin
			rd_value[`CMC_NBUF-1:0] = cancel_q;
		end else if (reg_hit(dp_addr_q, `CMC_OFF_SENT)) begin
			rd_value[`CMC_NBUF-1:0] = sent_q;
		end else if (reg_hit(dp_addr_q, `CMC_OFF_ABORT)) begin
			rd_value[`CMC_NBUF-1:0] = abort_q;
		end else if (reg_hit(dp_addr_q, `CMC_OFF_STAT)) begin
			rd_value[`CMC_STAT_MON]  = monitor;
			rd_value[`CMC_STAT_IDLE] = core_bus_idle;
			rd_value[`CMC_STAT_TIER_HI:`CMC_STAT_TIER_LO] = fault_tier;
			rd_value[`CMC_STAT_CS_HI:`CMC_STAT_CS_LO] = cs_q;
		end
	end

	// Control register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			diag_en_q <= 1'b0;
			listen_q  <= 1'b0;
			noretry_q <= 1'b0;
			csr_q     <= 1'b0;
			restr_q   <= 1'b0;
			evt_en_q  <= 1'b0;
		end else if (clk_en && wr_ctrl) begin
			diag_en_q <= hwdata[`CMC_CTRL_DIAG];
			listen_q  <= hwdata[`CMC_CTRL_LISTEN];
			noretry_q <= hwdata[`CMC_CTRL_NORETRY];
			csr_q     <= hwdata[`CMC_CTRL_CSR];
			restr_q   <= hwdata[`CMC_CTRL_RESTR];
			evt_en_q  <= hwdata[`CMC_CTRL_EVTEN];
		end
	end

	// Configuration hold bit, shared by software and clock stop
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hold_q <= `CMC_HOLD_RST;
		end else if (clk_en) begin
			// hold set once idle reached, ahead of ack
			if (cs_d == cmc_pkg::CMC_CS_HOLD) begin
				hold_q <= 1'b1;
			end else if (wr_ctrl && cs_q != cmc_pkg::CMC_CS_HOLD &&
			             cs_q != cmc_pkg::CMC_CS_ACK) begin
				hold_q <= hwdata[`CMC_CTRL_HOLD];
			end
		end
	end

	// Test register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			drive_q <= cmc_pkg::CMC_DRV_SERIAL;
			lbk_q   <= 1'b0;
		end else if (clk_en && wr_test && diag_en_q) begin
			drive_q <= hwdata[`CMC_TEST_DRV_HI:`CMC_TEST_DRV_LO];
			lbk_q   <= hwdata[`CMC_TEST_LBK];
		end
	end

	// drive selection passes a two stage sync
	cmc_sync #(.W(2)) u_drive_sync (
		.clock (clock),
		.rst_n (rst_n),
		.clk_en(clk_en),
		.d     (drive_q),
		.q     (drive_sync)
	);

	// receive pin passes a two stage sync
	cmc_sync #(.W(1)) u_rx_sync (
		.clock (clock),
		.rst_n (rst_n),
		.clk_en(clk_en),
		.d     (can_rx),
		.q     (rx_sample)
	);

	// monitoring by bit or severe fault tier
	assign monitor  = listen_q || (fault_tier == `CMC_TIER_SEVERE);
	assign int_loop = lbk_q && listen_q;

	// Pin multiplexing
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			can_tx      <= `CMC_RECESSIVE;
			core_rx_bit <= `CMC_RECESSIVE;
		end else if (clk_en) begin
			if (int_loop || monitor) begin
				can_tx <= `CMC_RECESSIVE;
			end else begin
				case (drive_sync)
					cmc_pkg::CMC_DRV_SERIAL:    can_tx <= core_tx_bit;
					cmc_pkg::CMC_DRV_SAMPLE:    can_tx <= core_sample_point;
					cmc_pkg::CMC_DRV_DOMINANT:  can_tx <= `CMC_DOMINANT;
					cmc_pkg::CMC_DRV_RECESSIVE: can_tx <= `CMC_RECESSIVE;
					default:                    can_tx <= `CMC_RECESSIVE;
				endcase
			end
			// loop back ignores the receive pin
			if (lbk_q) begin
				core_rx_bit <= core_tx_bit;
			// own dominant bits seen while monitoring
			end else if (monitor) begin
				core_rx_bit <= can_rx & core_tx_bit;
			end else begin
				core_rx_bit <= can_rx;
			end
		end
	end

	assign loopback_store = lbk_q;
	// no acknowledge error in loop back
	assign ack_error_mask = lbk_q;
	assign restricted_op  = restr_q;
	assign config_hold    = hold_q;
	assign tx_auto_retry  = !noretry_q;
	// no frame start while monitoring or held
	assign tx_request     = (monitor || hold_q) ? '0 : pend_q;

	assign cur_sel    = buf_sel(tx_buf_idx);
	assign frame_fail = tx_arb_lost || tx_error;
	assign frame_end  = tx_success || frame_fail;

	// Per buffer request and outcome flags
	genvar gi;
	generate
		for (gi = 0; gi < `CMC_NBUF; gi++) begin : g_buf
			logic hit;
			logic req_set;
			logic drop_now;
			logic fail_clr;
			logic pend_clr;
			logic abort_set;

			assign hit      = cur_sel[gi] && frame_end;
			assign req_set  = wr_pend && hwdata[gi] && !pend_q[gi];
			assign drop_now = pend_q[gi] && cancel_q[gi] && !started_q[gi];
			// without retry any outcome ends the request
			assign fail_clr = hit && frame_fail &&
			                  (noretry_q || cancel_q[gi]);
			assign pend_clr = (hit && tx_success) || fail_clr || drop_now;
			// abort on cancel win or lost frame
			assign abort_set = (hit && tx_success && cancel_q[gi]) ||
			                   fail_clr || drop_now;

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					pend_q[gi] <= 1'b0;
				end else if (clk_en) begin
					// pending held in reset while monitoring
					if (monitor) begin
						pend_q[gi] <= 1'b0;
					end else if (req_set) begin
						pend_q[gi] <= 1'b1;
					end else if (pend_clr) begin
						pend_q[gi] <= 1'b0;
					end
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					cancel_q[gi]  <= 1'b0;
					started_q[gi] <= 1'b0;
				end else if (clk_en) begin
					if (wr_cancel && hwdata[gi] && pend_q[gi]) begin
						cancel_q[gi] <= 1'b1;
					end else if (pend_clr || !pend_q[gi]) begin
						cancel_q[gi] <= 1'b0;
					end
					if (tx_start && cur_sel[gi]) begin
						started_q[gi] <= 1'b1;
					end else if (hit || !pend_q[gi]) begin
						started_q[gi] <= 1'b0;
					end
				end
			end

			// Outcome flags restart with each new request; set wins
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					sent_q[gi]  <= 1'b0;
					abort_q[gi] <= 1'b0;
				end else if (clk_en) begin
					if (hit && tx_success) begin
						sent_q[gi] <= 1'b1;
					end else if (req_set) begin
						sent_q[gi] <= 1'b0;
					end
					if (abort_set) begin
						abort_q[gi] <= 1'b1;
					end else if (req_set) begin
						abort_q[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Transmit event entry
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			evt_wr   <= 1'b0;
			evt_type <= `CMC_EVT_TX;
			evt_buf  <= '0;
		end else if (clk_en) begin
			evt_wr <= tx_success && evt_en_q;
			if (tx_success && evt_en_q) begin
				evt_type <= noretry_q ? `CMC_EVT_DESPITE : `CMC_EVT_TX;
				evt_buf  <= tx_buf_idx;
			end
		end
	end

	// stop request from input or bit
	assign stop_req = csr_q || clock_stop_req_in;

	always_comb begin
		cs_d = cs_q;
		case (cs_q)
			cmc_pkg::CMC_CS_RUN: begin
				if (stop_req) begin
					cs_d = cmc_pkg::CMC_CS_DRAIN;
				end
			end
			cmc_pkg::CMC_CS_DRAIN: begin
				if (pend_q == '0) begin
					cs_d = cmc_pkg::CMC_CS_IDLEW;
				end
			end
			cmc_pkg::CMC_CS_IDLEW: begin
				if (core_bus_idle) begin
					cs_d = cmc_pkg::CMC_CS_HOLD;
				end
			end
			cmc_pkg::CMC_CS_HOLD: begin
				cs_d = cmc_pkg::CMC_CS_ACK;
			end
			cmc_pkg::CMC_CS_ACK: begin
				cs_d = cmc_pkg::CMC_CS_ACK;
			end
			default: begin
				cs_d = cmc_pkg::CMC_CS_RUN;
			end
		endcase
		if (!stop_req) begin
			cs_d = cmc_pkg::CMC_CS_RUN;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cs_q <= cmc_pkg::CMC_CS_RUN;
		end else if (clk_en) begin
			cs_q <= cs_d;
		end
	end

	assign clock_stop_ack_out = (cs_q == cmc_pkg::CMC_CS_ACK);

endmodule

// ==== bench/cmc_props.sv ====
`include "cmc_defines.svh"

module cmc_props (
	// Clock and reset
	input wire logic                 clock,
	input wire logic                 rst_n,
	input wire logic                 clk_en,
	// Register bus
	input wire logic                 hsel,
	input wire logic [1:0]           htrans,
	input wire logic                 hwrite,
	input wire logic                 hready,
	input wire logic                 hreadyout,
	input wire logic                 hresp,
	// Pins and core
	input wire logic                 can_tx,
	input wire logic                 can_rx,
	input wire logic                 core_tx_bit,
	input wire logic                 core_rx_bit,
	input wire logic [1:0]           fault_tier,
	input wire logic                 loopback_store,
	input wire logic                 ack_error_mask,
	// Buffers and stop
	input wire logic [`CMC_NBUF-1:0] tx_request,
	input wire logic                 tx_auto_retry,
	input wire logic                 tx_success,
	input wire logic                 tx_arb_lost,
	input wire logic                 tx_error,
	input wire logic [`CMC_BUFW-1:0] tx_buf_idx,
	input wire logic                 evt_wr,
	input wire logic [1:0]           evt_type,
	input wire logic [`CMC_BUFW-1:0] evt_buf,
	input wire logic                 clock_stop_ack_out,
	input wire logic                 config_hold
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	rd_wait_a: assert property (clk_en && hsel && hready && htrans[1]
		&& !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	bus_okay_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	mon_tx_a: assert property (
		(fault_tier == 2'h3)[*3] |-> can_tx)
		else $error("dominant on pin while monitoring");
	mon_pend_a: assert property (
		(fault_tier == 2'h3)[*2] |-> tx_request == '0)
		else $error("request while monitoring");
	mon_rx_a: assert property (
		(fault_tier == 2'h3)[*2] ##0 !loopback_store
		|=> core_rx_bit == $past(can_rx & core_tx_bit))
		else $error("monitor receive path wrong");
	lbk_rx_a: assert property (
		loopback_store |=> core_rx_bit == $past(core_tx_bit))
		else $error("loop back receive path wrong");
	lbk_mask_a: assert property (
		ack_error_mask == loopback_store)
		else $error("ack error mask wrong");
	retry_off_a: assert property (
		!tx_auto_retry && (tx_success || tx_arb_lost || tx_error)
		|=> !tx_request[$past(tx_buf_idx)])
		else $error("pending kept after outcome");
	evt_type_a: assert property (
		evt_wr |-> $past(tx_success) && evt_buf == $past(tx_buf_idx)
		&& (tx_auto_retry || evt_type == 2'h2))
		else $error("event entry wrong");
	hold_ack_a: assert property (
		$rose(clock_stop_ack_out) |-> $past(config_hold))
		else $error("ack before hold");
	ack_hold_a: assert property (
		clock_stop_ack_out |-> config_hold)
		else $error("hold cleared while acknowledged");
endmodule

bind cmc_top cmc_props chk_u (.*);

// ==== bench/cmc_bus_model.sv ====
module cmc_bus_model (
	// Node side
	input  wire logic can_tx,
	output logic      can_rx,
	// Other nodes
	input  wire logic other_dom
);
	timeunit 1ns;
	timeprecision 1ns;
	// Wired-AND bus: any node pulling low wins
	assign can_rx = can_tx & ~other_dom;
endmodule

// ==== bench/tb.sv ====
`include "cmc_defines.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock, rst_n, clk_en, hsel, hwrite, hready, hreadyout;
	logic        hresp, can_tx, can_rx, other_dom, core_tx_bit;
	logic        clock_stop_req_in, clock_stop_ack_out, core_sample_point;
	logic        core_bus_idle, tx_start, tx_success, tx_arb_lost;
	logic        tx_error, core_rx_bit, tx_auto_retry, ack_error_mask;
	logic        loopback_store, restricted_op, config_hold, evt_wr;
	logic [1:0]  htrans, fault_tier, tx_buf_idx, evt_type, evt_buf;
	logic [1:0]  last_evt = 2'h0;
	logic [2:0]  hsize;
	logic [3:0]  tx_request, oc [4], sent_e, abort_e;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int          err_count, n_compared;

	cmc_top dut_u (.*);
	cmc_bus_model bus_u (.can_tx(can_tx), .can_rx(can_rx),
		.other_dom(other_dom));
	assign hready = hreadyout;

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	always @(posedge clock) if (evt_wr === 1'b1) last_evt <= evt_type;

	task stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task fail(input string s);
		err_count++;
		$display("[ERR] %0t %s", $time, s);
	endtask

	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) fail("register value");
	endtask

	task chk_pin(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) fail("pin level");
	endtask

	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		logic r;
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		for (int p = 0; p < 2; p++) begin
			n = 0;
			do begin
				@(negedge clock);
				r = hready;
				n++;
				if (n > 40) begin
					fail("bus timeout");
					stop_test();
				end
				if (r === 1'b1 && p == 1) rd = hrdata;
				@(posedge clock);
			end while (r !== 1'b1);
			if (p == 0) begin
				htrans <= 2'h0;
				hsel <= 1'b0;
				hwdata <= wd;
			end
		end
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk_reg(rd, exp);
	endtask

	task settle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask

	task ev(input logic [3:0] s, input logic [1:0] b);
		@(posedge clock);
		tx_buf_idx <= b;
		{tx_error, tx_arb_lost, tx_success, tx_start} <= s;
		@(posedge clock);
		{tx_error, tx_arb_lost, tx_success, tx_start} <= 4'h0;
	endtask

	task wait_ack(input logic v);
		int n;
		n = 0;
		while (clock_stop_ack_out !== v) begin
			@(negedge clock);
			n++;
			if (n > 100) begin
				fail("ack timeout");
				stop_test();
			end
		end
	endtask

	initial begin
		{rst_n, hsel, hwrite, htrans, haddr, hwdata, other_dom} = '0;
		{clock_stop_req_in, core_sample_point} = '0;
		core_tx_bit = `CMC_RECESSIVE;
		{fault_tier, tx_start, tx_success, tx_arb_lost, tx_error} = '0;
		{tx_buf_idx, err_count, n_compared} = '0;
		clk_en = 1'b1;
		hsize = `CMC_HSIZE_WORD;
		core_bus_idle = 1'b1;
		oc = '{4'h2, 4'h2, 4'h4, 4'h8};
		sent_e = 4'b0011;
		abort_e = 4'b1110;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		rdc(`CMC_OFF_CTRL, 32'h1);
		chk_pin(tx_auto_retry, 1'b1);
		ahb(1'b1, `CMC_OFF_CTRL, 32'h0);
		ahb(1'b1, `CMC_OFF_TEST, 32'h3);
		rdc(`CMC_OFF_TEST, 32'h8);
		ahb(1'b1, `CMC_OFF_CTRL, 32'h2);
		for (int s = 0; s < 2; s++) begin
			@(posedge clock);
			core_tx_bit <= s[0];
			core_sample_point <= ~s[0];
			for (int k = 0; k < 4; k++) begin
				ahb(1'b1, `CMC_OFF_TEST, k);
				settle(3);
				chk_pin(can_tx, k > 1 ? k[0] : s[0] ^ k[0]);
			end
		end
		$display("test drive done");
		@(posedge clock);
		other_dom <= 1'b1;
		settle(3);
		rdc(`CMC_OFF_TEST, 32'h3);
		other_dom <= 1'b0;
		core_tx_bit <= 1'b0;
		ahb(1'b1, `CMC_OFF_TEST, 32'h7);
		settle(4);
		chk_pin(core_rx_bit, 1'b0);
		chk_pin(loopback_store, 1'b1);
		chk_pin(ack_error_mask, 1'b1);
		chk_pin(restricted_op, 1'b0);
		ahb(1'b1, `CMC_OFF_TEST, 32'h4);
		settle(4);
		chk_pin(can_tx, 1'b0);
		ahb(1'b1, `CMC_OFF_CTRL, 32'h6);
		settle(4);
		chk_pin(can_tx, 1'b1);
		chk_pin(core_rx_bit, 1'b0);
		$display("test loop back done");
		ahb(1'b1, `CMC_OFF_TEST, 32'h0);
		settle(4);
		chk_pin(can_tx, 1'b1);
		chk_pin(core_rx_bit, 1'b0);
		@(posedge clock);
		core_tx_bit <= 1'b1;
		other_dom <= 1'b1;
		settle(3);
		chk_pin(core_rx_bit, 1'b0);
		ahb(1'b1, `CMC_OFF_PEND, 32'h1);
		@(negedge clock);
		chk_pin(tx_request[0], 1'b0);
		rdc(`CMC_OFF_PEND, 32'h0);
		core_tx_bit <= 1'b0;
		other_dom <= 1'b0;
		ahb(1'b1, `CMC_OFF_CTRL, 32'h2);
		fault_tier <= 2'h3;
		settle(4);
		chk_pin(can_tx, 1'b1);
		@(posedge clock);
		fault_tier <= 2'h0;
		$display("test monitoring done");
		ahb(1'b1, `CMC_OFF_CTRL, 32'h8a);
		@(negedge clock);
		chk_pin(tx_auto_retry, 1'b0);
		for (int i = 0; i < 4; i++) begin
			ahb(1'b1, `CMC_OFF_PEND, 32'h1 << i);
			@(negedge clock);
			chk_pin(tx_request[i], 1'b1);
			ev(4'h1, i);
			if (i == 1) ahb(1'b1, `CMC_OFF_CANCEL, 32'h2);
			ev(oc[i], i);
			rdc(`CMC_OFF_PEND, 32'h0);
			ahb(1'b0, `CMC_OFF_SENT, 32'h0);
			chk_pin(rd[i], sent_e[i]);
			ahb(1'b0, `CMC_OFF_ABORT, 32'h0);
			chk_pin(rd[i], abort_e[i]);
			if (i < 2) chk_reg({30'h0, last_evt}, 32'h2);
		end
		ahb(1'b1, `CMC_OFF_PEND, 32'h1);
		ahb(1'b1, `CMC_OFF_CANCEL, 32'h1);
		rdc(`CMC_OFF_PEND, 32'h0);
		ahb(1'b0, `CMC_OFF_ABORT, 32'h0);
		chk_pin(rd[0], 1'b1);
		ahb(1'b1, `CMC_OFF_CTRL, 32'h82);
		ahb(1'b1, `CMC_OFF_PEND, 32'h1);
		ev(4'h1, 2'h0);
		ev(4'h4, 2'h0);
		rdc(`CMC_OFF_PEND, 32'h1);
		ev(4'h1, 2'h0);
		ev(4'h2, 2'h0);
		settle(1);
		chk_reg({30'h0, last_evt}, 32'h1);
		$display("test retry done");
		ahb(1'b1, `CMC_OFF_CTRL, 32'h2);
		core_bus_idle <= 1'b0;
		clock_stop_req_in <= 1'b1;
		settle(6);
		chk_pin(clock_stop_ack_out, 1'b0);
		@(posedge clock);
		core_bus_idle <= 1'b1;
		wait_ack(1'b1);
		chk_pin(config_hold, 1'b1);
		rdc(`CMC_OFF_CTRL, 32'h33);
		ahb(1'b1, `CMC_OFF_CTRL, 32'h2);
		@(negedge clock);
		chk_pin(config_hold, 1'b1);
		@(posedge clock);
		clock_stop_req_in <= 1'b0;
		wait_ack(1'b0);
		rdc(`CMC_OFF_CTRL, 32'h3);
		ahb(1'b1, `CMC_OFF_CTRL, 32'h2);
		@(negedge clock);
		chk_pin(config_hold, 1'b0);
		ahb(1'b1, `CMC_OFF_CTRL, 32'h12);
		wait_ack(1'b1);
		chk_pin(clock_stop_ack_out, 1'b1);
		ahb(1'b1, `CMC_OFF_CTRL, 32'h2);
		wait_ack(1'b0);
		chk_pin(config_hold, 1'b1);
		$display("test clock stop done");
		stop_test();
	end
endmodule
